// >>> logic/stb_pkg.sv
// Shared constants and types for the sample timebase block.
// Assumes all users refer to names as stb_pkg::name.
package stb_pkg;

  // Board variant, one-hot
  typedef enum logic [7:0] {
    VAR_PLL_130  = 8'h01,
    VAR_PLL_500  = 8'h02,
    VAR_PLL_500D = 8'h04,
    VAR_PLL_1800 = 8'h08,
    VAR_PLL_1000 = 8'h10,
    VAR_PLL_4000 = 8'h20,
    VAR_PLL_DUAL = 8'h40,
    VAR_PLL_180  = 8'h80
  } stb_variant_t;

  // Field widths
  localparam int SRC_W = 2;
  localparam int RATE_W = 8;
  localparam int MHZ_W = 12;
  localparam int DEC_W = 17;
  localparam int LVL_W = 7;

  // Clock source codes
  localparam logic [1:0] SRC_OSC = 2'h0;
  localparam logic [1:0] SRC_EXT = 2'h1;
  localparam logic [1:0] SRC_PLL = 2'h2;

  // Frequencies in MHz
  localparam logic [11:0] MHZ_100 = 12'h064;
  localparam logic [11:0] MHZ_110 = 12'h06E;
  localparam logic [11:0] MHZ_125 = 12'h07D;
  localparam logic [11:0] MHZ_130 = 12'h082;
  localparam logic [11:0] MHZ_150 = 12'h096;
  localparam logic [11:0] MHZ_180 = 12'h0B4;
  localparam logic [11:0] MHZ_300 = 12'h12C;
  localparam logic [11:0] MHZ_500 = 12'h1F4;
  localparam logic [11:0] MHZ_1000 = 12'h3E8;
  localparam logic [11:0] MHZ_1800 = 12'h708;
  localparam logic [11:0] MHZ_2000 = 12'h7D0;
  localparam logic [11:0] MHZ_4000 = 12'hFA0;

  // Decimation figures
  localparam logic [16:0] DEC_ZERO = 17'h0_0000;
  localparam logic [16:0] DEC_ONE = 17'h0_0001;
  localparam logic [16:0] DEC_TWO = 17'h0_0002;
  localparam logic [16:0] DEC_FOUR = 17'h0_0004;
  localparam logic [16:0] DEC_FIVE = 17'h0_0005;
  localparam logic [16:0] DEC_MAX = 17'h1_86A0;
  localparam logic [16:0] DEC_MAX_M1 = 17'h1_869F;

  // Receiver level limit in percent
  localparam logic [6:0] LVL_MAX = 7'h64;

  // Reset values
  localparam logic [7:0] RST_RATE = 8'h00;
  localparam logic [11:0] RST_MHZ = 12'h000;
  localparam logic [6:0] RST_LVL = 7'h32;

endpackage

// >>> logic/stb_cfg_if.sv
// Carrier between the timebase top, its request checker and its decimator.
// Assumes one clock and one active-low reset shared by all three.
`timescale 1ns/100ps
interface stb_cfg_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic [1:0] req_source;
  logic [7:0] req_rate;
  logic [11:0] req_mhz;
  logic [16:0] req_decim;
  logic req_single;
  logic ok;
  logic [16:0] req_factor;
  logic [16:0] act_factor;
  logic act_falling;
  logic restart;
  logic src_level;
  logic keep;

  modport top (
    input clk, rst_n, ok, req_factor, keep,
    output req_source, req_rate, req_mhz, req_decim, req_single,
    output act_factor, act_falling, restart, src_level
  );
  modport chk (
    input clk, rst_n, req_source, req_rate, req_mhz, req_decim, req_single,
    output ok, req_factor
  );
  modport dec (
    input clk, rst_n, act_factor, act_falling, restart, src_level,
    output keep
  );
endinterface

// >>> logic/stb_cfg_check.sv
// Combinational legality check of a requested timebase configuration.
// Assumes the request fields are stable while the top samples the result.
`timescale 1ns/100ps
module stb_cfg_check #(
  parameter stb_pkg::stb_variant_t VARIANT = stb_pkg::VAR_PLL_130,
  parameter logic [7:0] RATE_ID_MIN = 8'h01,
  parameter logic [7:0] RATE_ID_MAX = 8'h20,
  parameter logic [7:0] USER_RATE_CODE = 8'h40
) (
  stb_cfg_if.chk cfg
);
  logic freq_ok;
  logic dec_ok;
  logic src_ok;
  logic [16:0] factor;
  logic [16:0] dv;
  logic [11:0] f;
  logic mult5;

  assign dv = cfg.req_decim;
  assign f = cfg.req_mhz;
  assign mult5 = (dv != stb_pkg::DEC_ZERO) && ((dv % stb_pkg::DEC_FIVE) == stb_pkg::DEC_ZERO);

  always_comb begin
    freq_ok = 1'b0;
    dec_ok = 1'b0;
    factor = dv;
    unique case (VARIANT)
      stb_pkg::VAR_PLL_130: begin
        freq_ok = (f >= stb_pkg::MHZ_110) && (f <= stb_pkg::MHZ_130);
        dec_ok = dv <= stb_pkg::DEC_MAX_M1;
        factor = dv + stb_pkg::DEC_ONE;
      end
      stb_pkg::VAR_PLL_500: begin
        freq_ok = f == stb_pkg::MHZ_500;
        dec_ok = (dv == stb_pkg::DEC_TWO || dv == stb_pkg::DEC_FOUR || mult5) && dv <= stb_pkg::DEC_MAX;
      end
      stb_pkg::VAR_PLL_500D: begin
        freq_ok = f == stb_pkg::MHZ_500;
        dec_ok = (dv == stb_pkg::DEC_ONE || dv == stb_pkg::DEC_TWO || dv == stb_pkg::DEC_FOUR || mult5)
                 && dv <= stb_pkg::DEC_MAX;
      end
      stb_pkg::VAR_PLL_1800: begin
        freq_ok = (f >= stb_pkg::MHZ_300) && (f <= stb_pkg::MHZ_1800);
        dec_ok = dv == stb_pkg::DEC_ONE;
      end
      stb_pkg::VAR_PLL_1000: begin
        freq_ok = (f >= stb_pkg::MHZ_300) && (f <= stb_pkg::MHZ_1000);
        dec_ok = dv == stb_pkg::DEC_ONE;
      end
      stb_pkg::VAR_PLL_4000: begin
        freq_ok = ((f >= stb_pkg::MHZ_300) && (f <= stb_pkg::MHZ_2000))
                  || ((f > stb_pkg::MHZ_2000) && (f <= stb_pkg::MHZ_4000) && !f[0] && cfg.req_single);
        dec_ok = dv == stb_pkg::DEC_ONE;
      end
      stb_pkg::VAR_PLL_DUAL: begin
        freq_ok = (f == stb_pkg::MHZ_100) || (f == stb_pkg::MHZ_125);
        dec_ok = (dv == stb_pkg::DEC_ONE || dv == stb_pkg::DEC_TWO || dv == stb_pkg::DEC_FOUR || mult5)
                 && dv <= stb_pkg::DEC_MAX;
      end
      stb_pkg::VAR_PLL_180: begin
        freq_ok = (f >= stb_pkg::MHZ_150) && (f <= stb_pkg::MHZ_180);
        dec_ok = dv <= stb_pkg::DEC_MAX_M1;
        factor = dv + stb_pkg::DEC_ONE;
      end
      default: begin
        freq_ok = 1'b0;
        dec_ok = 1'b0;
      end
    endcase
  end

  always_comb begin
    unique case (cfg.req_source)
      stb_pkg::SRC_OSC: src_ok = cfg.req_rate >= RATE_ID_MIN && cfg.req_rate <= RATE_ID_MAX;
      stb_pkg::SRC_EXT: src_ok = cfg.req_rate == USER_RATE_CODE;
      stb_pkg::SRC_PLL: src_ok = freq_ok;
      default: src_ok = 1'b0;
    endcase
  end

  assign cfg.ok = src_ok && dec_ok;
  assign cfg.req_factor = factor;

  chk_fixed_decim: assert property (@(posedge cfg.clk) disable iff (!cfg.rst_n)
    (cfg.ok && (VARIANT == stb_pkg::VAR_PLL_1800 || VARIANT == stb_pkg::VAR_PLL_1000)) |-> dv == stb_pkg::DEC_ONE)
    else $error("decimation other than one accepted");
  chk_factor_offset: assert property (@(posedge cfg.clk) disable iff (!cfg.rst_n)
    (cfg.ok && VARIANT == stb_pkg::VAR_PLL_130) |-> cfg.req_factor == dv + stb_pkg::DEC_ONE
    && cfg.req_factor >= stb_pkg::DEC_ONE && cfg.req_factor <= stb_pkg::DEC_MAX)
    else $error("factor is not value plus one");
  chk_no_unit_factor: assert property (@(posedge cfg.clk) disable iff (!cfg.rst_n)
    (cfg.ok && VARIANT == stb_pkg::VAR_PLL_500) |-> dv != stb_pkg::DEC_ONE)
    else $error("factor one accepted on strict variant");
endmodule

// >>> logic/stb_decimator.sv
// Edge selection and one-in-N sample keeping on the chosen clock level.
// Assumes the clock level is synchronous and restart is a one-cycle pulse.
`timescale 1ns/100ps
module stb_decimator (
  stb_cfg_if.dec cfg
);
  logic prev_ff;
  logic [16:0] cnt_ff;
  logic [16:0] nxt_cnt;
  logic edge_seen;

  assign edge_seen = cfg.act_falling ? (prev_ff && !cfg.src_level) : (!prev_ff && cfg.src_level);
  assign cfg.keep = edge_seen && !cfg.restart && cnt_ff == stb_pkg::DEC_ZERO;

  always_comb begin
    nxt_cnt = cnt_ff;
    if (cfg.restart) begin
      nxt_cnt = stb_pkg::DEC_ZERO;
    end else if (edge_seen) begin
      nxt_cnt = (cnt_ff >= cfg.act_factor - stb_pkg::DEC_ONE) ? stb_pkg::DEC_ZERO : cnt_ff + stb_pkg::DEC_ONE;
    end
  end

  always_ff @(posedge cfg.clk or negedge cfg.rst_n) begin
    if (!cfg.rst_n) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= cfg.src_level;
    end
  end

  always_ff @(posedge cfg.clk or negedge cfg.rst_n) begin
    if (!cfg.rst_n) begin
      cnt_ff <= stb_pkg::DEC_ZERO;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  chk_restart_zero: assert property (@(posedge cfg.clk) disable iff (!cfg.rst_n)
    cfg.restart |=> cnt_ff == stb_pkg::DEC_ZERO)
    else $error("counter not restarted");
  chk_keep_on_edge: assert property (@(posedge cfg.clk) disable iff (!cfg.rst_n)
    cfg.keep |-> (cfg.src_level != $past(cfg.src_level)) && (cfg.src_level == !cfg.act_falling))
    else $error("sample kept off the selected edge");
  chk_unit_every: assert property (@(posedge cfg.clk) disable iff (!cfg.rst_n)
    (cfg.act_factor == stb_pkg::DEC_ONE && edge_seen && !cfg.restart) |-> cfg.keep)
    else $error("factor one dropped an edge");
endmodule

// >>> logic/stb_timebase.sv
// Timebase top: source select, rate/PLL setup, receiver level, decimated sampling.
// Assumes all inputs synchronous to CLOCK; apply is a one-cycle strobe.
// How it works
// - Three sources: oscillator, connector clock, PLL
// - Oscillator source uses a supported rate identifier
// - Connector source needs the user rate code
// - Receiver threshold programmable in percent
// - PLL reference comes from the clock connector
// - Lowest variant: 110 to 130 MHz steps
// - Decimation value is factor minus one on the 130 and 180 variants
// - Strict 500 MHz: factors 2, 4, fives
// - Other 500 MHz variant also allows one
// - 1800 variant: 300-1800 MHz, decimation one
// - 1000 variant: 300-1000 MHz, no decimation
// - Above 2000 MHz: even steps, single channel
// - Dual variant: only 100 or 125 MHz
// - 180 variant: 150-180 MHz, wide decimation
`timescale 1ns/100ps
module stb_timebase #(
  parameter stb_pkg::stb_variant_t VARIANT = stb_pkg::VAR_PLL_130,
  parameter logic [7:0] RATE_ID_MIN = 8'h01,
  parameter logic [7:0] RATE_ID_MAX = 8'h20,
  parameter logic [7:0] USER_RATE_CODE = 8'h40,
  parameter int DATA_W = 14
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RESET_N,
  // Configuration request
  input wire logic CFG_APPLY,
  input wire logic [1:0] CFG_SOURCE,
  input wire logic [7:0] CFG_RATE_CODE,
  input wire logic [11:0] CFG_PLL_MHZ,
  input wire logic [16:0] CFG_DECIM,
  input wire logic CFG_EDGE_FALLING,
  input wire logic CFG_SINGLE_CHANNEL,
  // Receiver threshold
  input wire logic LEVEL_WRITE,
  input wire logic [6:0] LEVEL_PCT_IN,
  // Clock source levels
  input wire logic OSC_CLOCK_LEVEL,
  input wire logic CONNECTOR_CLOCK_LEVEL,
  input wire logic PLL_CLOCK_LEVEL,
  // Converter data
  input wire logic [DATA_W-1:0] ADC_DATA,
  // Request answer
  output logic CFG_ACCEPT,
  output logic CFG_REJECT,
  // Active configuration
  output logic [1:0] ACTIVE_SOURCE,
  output logic [7:0] ACTIVE_RATE_CODE,
  output logic [11:0] ACTIVE_PLL_MHZ,
  output logic [16:0] ACTIVE_FACTOR,
  output logic ACTIVE_EDGE_FALLING,
  output logic PLL_ENABLE,
  output logic PLL_REF_FROM_CONNECTOR,
  output logic [6:0] EXT_LEVEL_PCT,
  // Sample stream
  output logic SAMPLE_VALID,
  output logic [DATA_W-1:0] SAMPLE_DATA
);
  stb_cfg_if cfg (.clk(CLOCK), .rst_n(RESET_N));

  logic accept_ff;
  logic reject_ff;
  logic restart_ff;
  logic [1:0] source_ff;
  logic [7:0] rate_ff;
  logic [11:0] mhz_ff;
  logic [16:0] factor_ff;
  logic falling_ff;
  logic [6:0] level_ff;
  logic valid_ff;
  logic [DATA_W-1:0] data_ff;
  logic take;

  assign cfg.req_source = CFG_SOURCE;
  assign cfg.req_rate = CFG_RATE_CODE;
  assign cfg.req_mhz = CFG_PLL_MHZ;
  assign cfg.req_decim = CFG_DECIM;
  assign cfg.req_single = CFG_SINGLE_CHANNEL;
  assign cfg.act_factor = factor_ff;
  assign cfg.act_falling = falling_ff;
  assign cfg.restart = restart_ff;

  stb_cfg_check #(
    .VARIANT(VARIANT),
    .RATE_ID_MIN(RATE_ID_MIN),
    .RATE_ID_MAX(RATE_ID_MAX),
    .USER_RATE_CODE(USER_RATE_CODE)
  ) u_check (
    .cfg(cfg)
  );

  stb_decimator u_decim (
    .cfg(cfg)
  );

  assign take = CFG_APPLY && cfg.ok;

  // Converter clock mux on the active source
  always_comb begin
    unique case (source_ff)
      stb_pkg::SRC_OSC: cfg.src_level = OSC_CLOCK_LEVEL;
      stb_pkg::SRC_EXT: cfg.src_level = CONNECTOR_CLOCK_LEVEL;
      stb_pkg::SRC_PLL: cfg.src_level = PLL_CLOCK_LEVEL;
      default: cfg.src_level = 1'b0;
    endcase
  end

  // Active configuration, replaced only by a legal request
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      source_ff <= stb_pkg::SRC_OSC;
      rate_ff <= stb_pkg::RST_RATE;
      mhz_ff <= stb_pkg::RST_MHZ;
      factor_ff <= stb_pkg::DEC_ONE;
      falling_ff <= 1'b0;
    end else if (take) begin
      source_ff <= CFG_SOURCE;
      rate_ff <= CFG_RATE_CODE;
      mhz_ff <= CFG_PLL_MHZ;
      factor_ff <= cfg.req_factor;
      falling_ff <= CFG_EDGE_FALLING;
    end
  end

  // Answer pulses and decimator restart
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      accept_ff <= 1'b0;
      reject_ff <= 1'b0;
      restart_ff <= 1'b0;
    end else begin
      accept_ff <= take;
      reject_ff <= CFG_APPLY && !cfg.ok;
      restart_ff <= take;
    end
  end

  // Receiver threshold; out-of-range percentages ignored
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      level_ff <= stb_pkg::RST_LVL;
    end else if (LEVEL_WRITE && LEVEL_PCT_IN <= stb_pkg::LVL_MAX) begin
      level_ff <= LEVEL_PCT_IN;
    end
  end

  // Kept samples
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      valid_ff <= 1'b0;
      data_ff <= '0;
    end else begin
      valid_ff <= cfg.keep;
      if (cfg.keep) begin
        data_ff <= ADC_DATA;
      end
    end
  end

  assign CFG_ACCEPT = accept_ff;
  assign CFG_REJECT = reject_ff;
  assign ACTIVE_SOURCE = source_ff;
  assign ACTIVE_RATE_CODE = rate_ff;
  assign ACTIVE_PLL_MHZ = mhz_ff;
  assign ACTIVE_FACTOR = factor_ff;
  assign ACTIVE_EDGE_FALLING = falling_ff;
  assign PLL_ENABLE = source_ff == stb_pkg::SRC_PLL;
  assign PLL_REF_FROM_CONNECTOR = source_ff == stb_pkg::SRC_PLL;
  assign EXT_LEVEL_PCT = level_ff;
  assign SAMPLE_VALID = valid_ff;
  assign SAMPLE_DATA = data_ff;

  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RESET_N);

  chk_reject_keeps: assert property ((CFG_APPLY && !cfg.ok) |=>
    $stable(source_ff) && $stable(mhz_ff) && $stable(factor_ff) && reject_ff && !accept_ff)
    else $error("rejected request altered setup");
  chk_accept_loads: assert property (take |=>
    source_ff == $past(CFG_SOURCE) && falling_ff == $past(CFG_EDGE_FALLING) && accept_ff)
    else $error("accepted request not loaded");
  chk_ext_code: assert property ((accept_ff && source_ff == stb_pkg::SRC_EXT) |->
    rate_ff == USER_RATE_CODE)
    else $error("connector source without user rate code");
  chk_osc_rate: assert property ((accept_ff && source_ff == stb_pkg::SRC_OSC) |->
    rate_ff >= RATE_ID_MIN && rate_ff <= RATE_ID_MAX)
    else $error("unsupported oscillator rate accepted");
  chk_pll_ref: assert property (PLL_ENABLE |-> PLL_REF_FROM_CONNECTOR && cfg.src_level == PLL_CLOCK_LEVEL)
    else $error("PLL reference not on connector");
  chk_level_range: assert property (level_ff <= stb_pkg::LVL_MAX)
    else $error("receiver level above limit");
  chk_hi_band: assert property ((accept_ff && source_ff == stb_pkg::SRC_PLL && mhz_ff > stb_pkg::MHZ_2000) |->
    !mhz_ff[0] && $past(CFG_SINGLE_CHANNEL))
    else $error("upper band accepted in odd step or dual mode");
  chk_dual_freq: assert property ((accept_ff && source_ff == stb_pkg::SRC_PLL && VARIANT == stb_pkg::VAR_PLL_DUAL)
    |-> (mhz_ff == stb_pkg::MHZ_100 || mhz_ff == stb_pkg::MHZ_125))
    else $error("dual variant off its two frequencies");
  chk_low_band: assert property ((accept_ff && source_ff == stb_pkg::SRC_PLL && VARIANT == stb_pkg::VAR_PLL_130)
    |-> (mhz_ff >= stb_pkg::MHZ_110 && mhz_ff <= stb_pkg::MHZ_130))
    else $error("low variant frequency out of band");
  chk_valid_pulse: assert property (valid_ff |-> ##1 !valid_ff || factor_ff == stb_pkg::DEC_ONE)
    else $error("back-to-back samples with factor above one");

  cov_pll_accept: cover property (accept_ff && source_ff == stb_pkg::SRC_PLL);
  cov_ext_accept: cover property (accept_ff && source_ff == stb_pkg::SRC_EXT);
  cov_reject: cover property (reject_ff);
  cov_decimated: cover property (valid_ff && factor_ff > stb_pkg::DEC_ONE);
endmodule

// >>> verification/stb_clock_source.sv
// Behavioural far-side clock source: oscillator, connector clock or PLL output.
// Assumes its outputs are sampled on the rising edge of the same system clock.
`timescale 1ns/100ps
module stb_clock_source (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Burst control
  input wire logic run,
  input wire logic [3:0] half,
  // Source level
  output logic level
);
  logic [3:0] cnt_ff;

  // Stands low outside a burst; toggles every half cycles inside one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 4'h0;
      level <= 1'b0;
    end else if (!run) begin
      cnt_ff <= 4'h0;
      level <= 1'b0;
    end else if (cnt_ff == half - 4'h1) begin
      cnt_ff <= 4'h0;
      level <= ~level;
    end else begin
      cnt_ff <= cnt_ff + 4'h1;
    end
  end
endmodule

// >>> verification/test_stb_timebase.sv
// Self-checking bench: lowest-rate variant in full, the other variants by their answers.
// Assumes three far-side clock source models and a free-running data counter.
`timescale 1ns/100ps
module test_stb_timebase;
  typedef struct packed {
    logic [1:0] src;
    logic [7:0] rate;
    logic [11:0] mhz;
    logic [16:0] decim;
    logic sc;
    // Accept mask, bit n for the variant coded 1 << n
    logic [7:0] accv;
    logic [16:0] factor;
  } stb_row_t;

  logic clock, reset_n, cfg_apply, cfg_edge_falling, cfg_single_channel, level_write;
  logic [1:0] cfg_source;
  logic [7:0] cfg_rate_code;
  logic [11:0] cfg_pll_mhz;
  logic [16:0] cfg_decim;
  logic [6:0] level_pct_in, ext_level_pct;
  logic [13:0] adc_data, adc_d, sample_data;
  logic [2:0] run, lvl;
  logic cfg_accept, cfg_reject, active_edge_falling, pll_enable, pll_ref_from_connector, sample_valid;
  logic [1:0] active_source, exp_src;
  logic [7:0] active_rate_code, exp_rate;
  logic [11:0] active_pll_mhz, exp_mhz;
  logic [16:0] active_factor, exp_fac;
  int miscompares, check_count, vcount;
  stb_row_t rows [27];

  stb_timebase dut (.CLOCK(clock), .RESET_N(reset_n), .CFG_APPLY(cfg_apply), .CFG_SOURCE(cfg_source),
    .CFG_RATE_CODE(cfg_rate_code), .CFG_PLL_MHZ(cfg_pll_mhz), .CFG_DECIM(cfg_decim),
    .CFG_EDGE_FALLING(cfg_edge_falling), .CFG_SINGLE_CHANNEL(cfg_single_channel),
    .LEVEL_WRITE(level_write), .LEVEL_PCT_IN(level_pct_in), .OSC_CLOCK_LEVEL(lvl[0]),
    .CONNECTOR_CLOCK_LEVEL(lvl[1]), .PLL_CLOCK_LEVEL(lvl[2]), .ADC_DATA(adc_data),
    .CFG_ACCEPT(cfg_accept), .CFG_REJECT(cfg_reject), .ACTIVE_SOURCE(active_source),
    .ACTIVE_RATE_CODE(active_rate_code), .ACTIVE_PLL_MHZ(active_pll_mhz), .ACTIVE_FACTOR(active_factor),
    .ACTIVE_EDGE_FALLING(active_edge_falling), .PLL_ENABLE(pll_enable),
    .PLL_REF_FROM_CONNECTOR(pll_ref_from_connector), .EXT_LEVEL_PCT(ext_level_pct),
    .SAMPLE_VALID(sample_valid), .SAMPLE_DATA(sample_data));

  // Index 0 oscillator, 1 connector clock, 2 PLL output
  for (genvar g = 0; g < 3; g++) begin : g_src
    stb_clock_source src (.clk(clock), .rst_n(reset_n), .run(run[g]), .half(4'h2), .level(lvl[g]));
  end

  // Other variants share the stimulus; only their accept answers are compared
  wire [7:0] acc_v;
  assign acc_v[0] = cfg_accept;
  for (genvar v = 1; v < 8; v++) begin : g_var
    stb_timebase #(.VARIANT(stb_pkg::stb_variant_t'(8'h01 << v))) var_dut (.CLOCK(clock), .RESET_N(reset_n),
      .CFG_APPLY(cfg_apply), .CFG_SOURCE(cfg_source), .CFG_RATE_CODE(cfg_rate_code), .CFG_PLL_MHZ(cfg_pll_mhz),
      .CFG_DECIM(cfg_decim), .CFG_EDGE_FALLING(cfg_edge_falling), .CFG_SINGLE_CHANNEL(cfg_single_channel),
      .LEVEL_WRITE(level_write), .LEVEL_PCT_IN(level_pct_in), .OSC_CLOCK_LEVEL(lvl[0]),
      .CONNECTOR_CLOCK_LEVEL(lvl[1]), .PLL_CLOCK_LEVEL(lvl[2]), .ADC_DATA(adc_data), .CFG_ACCEPT(acc_v[v]),
      .CFG_REJECT(), .ACTIVE_SOURCE(), .ACTIVE_RATE_CODE(), .ACTIVE_PLL_MHZ(), .ACTIVE_FACTOR(),
      .ACTIVE_EDGE_FALLING(), .PLL_ENABLE(), .PLL_REF_FROM_CONNECTOR(), .EXT_LEVEL_PCT(), .SAMPLE_VALID(),
      .SAMPLE_DATA());
  end

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock) adc_data <= adc_data + 14'h0001;

  // Every kept sample carries the data seen at the detecting edge
  always @(posedge clock) begin
    if (sample_valid === 1'b1) begin
      vcount++;
      check(sample_data, adc_d, "sample data");
    end
    adc_d = adc_data;
  end

  task automatic check(input logic [16:0] got, input logic [16:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic apply(input logic [1:0] s, input logic [7:0] r, input logic [11:0] m,
      input logic [16:0] d, input logic f, input logic sc);
    @(posedge clock);
    cfg_source <= s;
    cfg_rate_code <= r;
    cfg_pll_mhz <= m;
    cfg_decim <= d;
    cfg_edge_falling <= f;
    cfg_single_channel <= sc;
    cfg_apply <= 1'b1;
    @(posedge clock);
    cfg_apply <= 1'b0;
    #1;
  endtask

  // Nine rising and nine falling edges, ending low
  task automatic burst(input int idx);
    @(negedge clock);
    vcount = 0;
    @(posedge clock);
    run[idx] <= 1'b1;
    repeat (36) @(posedge clock);
    run[idx] <= 1'b0;
    repeat (6) @(posedge clock);
    #1;
  endtask

  task automatic set_level(input logic [6:0] p);
    @(posedge clock);
    level_write <= 1'b1;
    level_pct_in <= p;
    @(posedge clock);
    level_write <= 1'b0;
    @(posedge clock);
    #1;
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d, mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    #(40 * 6000);
    miscompares++;
    $display("mismatch at %0t: watchdog expired", $time);
    report_and_stop();
  end

  initial begin
    rows[0] = '{stb_pkg::SRC_OSC, 8'h01, 12'h000, stb_pkg::DEC_ZERO, 1'b0, 8'h81, 17'h0_0001};
    rows[1] = '{stb_pkg::SRC_OSC, 8'h20, 12'h000, stb_pkg::DEC_TWO, 1'b0, 8'hC7, 17'h0_0003};
    rows[2] = '{stb_pkg::SRC_OSC, 8'h21, 12'h000, stb_pkg::DEC_ZERO, 1'b0, 8'h00, 17'h0_0000};
    rows[3] = '{stb_pkg::SRC_OSC, 8'h00, 12'h000, stb_pkg::DEC_ZERO, 1'b0, 8'h00, 17'h0_0000};
    rows[4] = '{stb_pkg::SRC_EXT, 8'h40, 12'h000, stb_pkg::DEC_ZERO, 1'b0, 8'h81, 17'h0_0001};
    rows[5] = '{stb_pkg::SRC_EXT, 8'h41, 12'h000, stb_pkg::DEC_ZERO, 1'b0, 8'h00, 17'h0_0000};
    rows[6] = '{stb_pkg::SRC_PLL, 8'h00, stb_pkg::MHZ_110, stb_pkg::DEC_MAX_M1, 1'b0, 8'h01, stb_pkg::DEC_MAX};
    rows[7] = '{stb_pkg::SRC_PLL, 8'h00, stb_pkg::MHZ_130, stb_pkg::DEC_ZERO, 1'b0, 8'h01, 17'h0_0001};
    rows[8] = '{stb_pkg::SRC_PLL, 8'h00, 12'h083, stb_pkg::DEC_ZERO, 1'b0, 8'h00, 17'h0_0000};
    rows[9] = '{stb_pkg::SRC_PLL, 8'h00, 12'h06D, stb_pkg::DEC_ZERO, 1'b0, 8'h00, 17'h0_0000};
    rows[10] = '{stb_pkg::SRC_PLL, 8'h00, 12'h078, stb_pkg::DEC_MAX, 1'b0, 8'h00, 17'h0_0000};
    rows[11] = '{2'h3, 8'h01, 12'h000, stb_pkg::DEC_ZERO, 1'b0, 8'h00, 17'h0_0000};
    rows[12] = '{stb_pkg::SRC_PLL, 8'h00, stb_pkg::MHZ_500, stb_pkg::DEC_FIVE, 1'b0, 8'h06, 17'h0_0000};
    rows[13] = '{stb_pkg::SRC_PLL, 8'h00, stb_pkg::MHZ_500, stb_pkg::DEC_ONE, 1'b0, 8'h3C, 17'h0_0000};
    rows[14] = '{stb_pkg::SRC_PLL, 8'h00, stb_pkg::MHZ_500, 17'h0_0003, 1'b0, 8'h00, 17'h0_0000};
    rows[15] = '{stb_pkg::SRC_PLL, 8'h00, stb_pkg::MHZ_500, 17'h1_86A5, 1'b0, 8'h00, 17'h0_0000};
    rows[16] = '{stb_pkg::SRC_PLL, 8'h00, stb_pkg::MHZ_1800, stb_pkg::DEC_ONE, 1'b0, 8'h28, 17'h0_0000};
    rows[17] = '{stb_pkg::SRC_PLL, 8'h00, stb_pkg::MHZ_1000, stb_pkg::DEC_ONE, 1'b0, 8'h38, 17'h0_0000};
    rows[18] = '{stb_pkg::SRC_PLL, 8'h00, stb_pkg::MHZ_300, stb_pkg::DEC_ONE, 1'b0, 8'h38, 17'h0_0000};
    rows[19] = '{stb_pkg::SRC_PLL, 8'h00, 12'h12B, stb_pkg::DEC_ONE, 1'b0, 8'h00, 17'h0_0000};
    rows[20] = '{stb_pkg::SRC_PLL, 8'h00, stb_pkg::MHZ_4000, stb_pkg::DEC_ONE, 1'b1, 8'h20, 17'h0_0000};
    rows[21] = '{stb_pkg::SRC_PLL, 8'h00, stb_pkg::MHZ_4000, stb_pkg::DEC_ONE, 1'b0, 8'h00, 17'h0_0000};
    rows[22] = '{stb_pkg::SRC_PLL, 8'h00, 12'hF9F, stb_pkg::DEC_ONE, 1'b1, 8'h00, 17'h0_0000};
    rows[23] = '{stb_pkg::SRC_PLL, 8'h00, stb_pkg::MHZ_100, 17'h0_000A, 1'b0, 8'h40, 17'h0_0000};
    rows[24] = '{stb_pkg::SRC_PLL, 8'h00, stb_pkg::MHZ_125, stb_pkg::DEC_ONE, 1'b0, 8'h41, 17'h0_0002};
    rows[25] = '{stb_pkg::SRC_PLL, 8'h00, stb_pkg::MHZ_150, stb_pkg::DEC_MAX_M1, 1'b0, 8'h80, 17'h0_0000};
    rows[26] = '{stb_pkg::SRC_PLL, 8'h00, 12'h0B5, stb_pkg::DEC_ZERO, 1'b0, 8'h00, 17'h0_0000};
    reset_n = 1'b0;
    cfg_apply = 1'b0;
    cfg_source = 2'h0;
    cfg_rate_code = 8'h00;
    cfg_pll_mhz = 12'h000;
    cfg_decim = 17'h0_0000;
    cfg_edge_falling = 1'b0;
    cfg_single_channel = 1'b0;
    level_write = 1'b0;
    level_pct_in = 7'h00;
    adc_data = 14'h0000;
    adc_d = 14'h0000;
    run = 3'h0;
    miscompares = 0;
    check_count = 0;
    vcount = 0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    check(active_source, stb_pkg::SRC_OSC, "reset source");
    check(active_factor, 17'h0_0001, "reset factor");
    check(ext_level_pct, stb_pkg::RST_LVL, "reset level");
    check(sample_valid, 1'b0, "reset valid");
    exp_src = stb_pkg::SRC_OSC;
    exp_rate = stb_pkg::RST_RATE;
    exp_mhz = stb_pkg::RST_MHZ;
    exp_fac = 17'h0_0001;
    // Host sets the timebase before any acquisition
    for (int i = 0; i < 27; i++) begin
      apply(rows[i].src, rows[i].rate, rows[i].mhz, rows[i].decim, 1'b0, rows[i].sc);
      check(cfg_accept, rows[i].accv[0], "accept");
      check(cfg_reject, !rows[i].accv[0], "reject");
      check(acc_v, rows[i].accv, "variant accept");
      if (rows[i].accv[0]) begin
        exp_src = rows[i].src;
        exp_fac = rows[i].factor;
        if (rows[i].src == stb_pkg::SRC_PLL) exp_mhz = rows[i].mhz;
        else exp_rate = rows[i].rate;
      end
      check(active_source, exp_src, "source");
      check(active_factor, exp_fac, "factor");
      check(pll_enable, exp_src == stb_pkg::SRC_PLL, "pll enable");
      check(pll_ref_from_connector, exp_src == stb_pkg::SRC_PLL, "pll reference");
      if (exp_src == stb_pkg::SRC_PLL) check(active_pll_mhz, exp_mhz, "pll mhz");
      else check(active_rate_code, exp_rate, "rate code");
    end
    apply(stb_pkg::SRC_OSC, 8'h05, 12'h000, stb_pkg::DEC_TWO, 1'b0, 1'b0);
    burst(1);
    check(vcount, 0, "unselected source");
    burst(0);
    check(vcount, 3, "one in three");
    apply(stb_pkg::SRC_EXT, 8'h40, 12'h000, stb_pkg::DEC_ZERO, 1'b1, 1'b0);
    check(active_edge_falling, 1'b1, "edge select");
    burst(1);
    check(vcount, 9, "falling edges");
    apply(stb_pkg::SRC_PLL, 8'h00, stb_pkg::MHZ_125, stb_pkg::DEC_ONE, 1'b0, 1'b0);
    burst(2);
    check(vcount, 5, "one in two");
    apply(stb_pkg::SRC_PLL, 8'h00, stb_pkg::MHZ_4000, stb_pkg::DEC_ONE, 1'b1, 1'b1);
    check(cfg_reject, 1'b1, "reject kept setup");
    burst(2);
    // No restart on a reject: the count resumes one edge into the pair, so edges 2, 4, 6, 8 are kept
    check(vcount, 4, "kept setup");
    set_level(stb_pkg::LVL_MAX);
    check(ext_level_pct, stb_pkg::LVL_MAX, "level max");
    set_level(7'h65);
    check(ext_level_pct, stb_pkg::LVL_MAX, "level over");
    set_level(7'h00);
    check(ext_level_pct, 7'h00, "level zero");
    // Mid-run reset brings back the defaults
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    #1;
    check(active_source, stb_pkg::SRC_OSC, "rerun source");
    check(active_factor, stb_pkg::DEC_ONE, "rerun factor");
    check(ext_level_pct, stb_pkg::RST_LVL, "rerun level");
    check(sample_data, 14'h0000, "rerun data");
    report_and_stop();
  end
endmodule
